//--- dv/mec_line_codec_assertions.sv
// port-level checks of the manchester line codec, bound to its top module
// assumes one core_clk domain and a mode pin held still around frames
`timescale 1ns/1ps

module mec_chk
    import mec_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // pins from outside
    input wire logic codec_bypass_select,
    input wire logic rx_squelch_ok,
    input wire logic collision_in_pair,
    input wire logic collision_squelch_ok,
    // codec outputs
    input wire logic mac_bit_clock,
    input wire logic mac_rx_valid,
    input wire logic mac_rx_eof,
    input wire logic mac_carrier_sense,
    input wire logic mac_collision,
    input wire logic pin_tx_en,
    input wire logic pair_drive_out_p,
    input wire logic pair_drive_out_n,
    input wire logic pair_drive_delayed_p,
    input wire logic pair_drive_delayed_n
);
    // ----
    // cycles since the collision pair last moved
    // ----
    logic       col_prev;
    logic [5:0] col_quiet;
    logic [5:0] next_col_quiet;

    always_comb begin
        next_col_quiet = col_quiet;
        if (collision_in_pair != col_prev) begin
            next_col_quiet = 6'h00;
        end else if (col_quiet != 6'h3F) begin
            next_col_quiet = col_quiet + 6'h01;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            col_prev  <= 1'b0;
            col_quiet <= 6'h00;
        end else begin
            col_prev  <= collision_in_pair;
            col_quiet <= next_col_quiet;
        end
    end

    // ----
    // properties
    // ----
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    sequence s_col_edge;
        $rose(collision_in_pair) && collision_squelch_ok && !codec_bypass_select;
    endsequence
    sequence s_tail_high;
        $past(pair_drive_out_p) && $past(pair_drive_out_p, 8);
    endsequence
    sequence s_tx_drained;
        ##[0:40] !pin_tx_en;
    endsequence

    property p_bypass_idle;
        $past(codec_bypass_select, 4) && codec_bypass_select
            |-> !pair_drive_out_p && !pair_drive_out_n;
    endproperty
    a_bypass_idle: assert property (p_bypass_idle) else $error("bypass drive");
    property p_levels;
        pair_drive_out_p == pair_drive_out_n |-> !pair_drive_out_p;
    endproperty
    a_levels: assert property (p_levels) else $error("both high");
    property p_tail;
        $fell(pair_drive_out_p || pair_drive_out_n) |-> s_tail_high;
    endproperty
    a_tail: assert property (p_tail) else $error("tail not high");
    property p_preemph;
        $changed(pair_drive_delayed_p) || $changed(pair_drive_delayed_n)
            |-> pair_drive_delayed_p == $past(pair_drive_out_p)
                && pair_drive_delayed_n == $past(pair_drive_out_n);
    endproperty
    a_preemph: assert property (p_preemph) else $error("delay copy");
    property p_squelch;
        $rose(mac_carrier_sense) && !codec_bypass_select |-> $past(rx_squelch_ok, 6);
    endproperty
    a_squelch: assert property (p_squelch) else $error("no squelch");
    property p_eof;
        mac_rx_valid && !codec_bypass_select |-> ##[1:37] (mac_rx_valid || mac_rx_eof);
    endproperty
    a_eof: assert property (p_eof) else $error("eof late");
    property p_col_on;
        s_col_edge |-> ##[1:20] mac_collision;
    endproperty
    a_col_on: assert property (p_col_on) else $error("no collision");
    property p_col_abort;
        $rose(mac_collision) && pin_tx_en |-> s_tx_drained;
    endproperty
    a_col_abort: assert property (p_col_abort) else $error("no abort");
    property p_col_off;
        col_quiet >= 6'h1E |-> !mac_collision;
    endproperty
    a_col_off: assert property (p_col_off) else $error("collision stuck");
    property p_bit_clock;
        $changed(mac_bit_clock) |=> $stable(mac_bit_clock)[*8] ##[4:5] $changed(mac_bit_clock);
    endproperty
    a_bit_clock: assert property (p_bit_clock) else $error("bit clock rate");
endmodule

bind mec_line_codec mec_chk mec_chk_i (.*);

//--- dv/mec_line_codec_tb.sv
// self-checking bench for the manchester line codec
// assumes the line partner model on the pairs; ext pins driven here
`timescale 1ns/1ps

module mec_line_codec_tb;
    import mec_pkg::*;

    // ----
    // signals
    // ----
    logic core_clk = 1'b0, reset = 1'b1, crystal_in = 1'b0, codec_bypass_select = 1'b0;
    logic mac_tx_valid = 1'b0, mac_tx_data = 1'b0, mac_tx_last = 1'b0;
    logic ext_rx_clk = 1'b0, ext_rx_data = 1'b0, ext_crs = 1'b0, ext_col = 1'b0;
    logic mac_tx_ready, mac_bit_clock, mac_rx_valid, mac_rx_data, mac_rx_eof, pin_tx_en;
    logic mac_carrier_sense, mac_collision, pin_tx_data, pin_rx_valid, pin_rx_data;
    logic pin_carrier_sense, pin_collision, rx_pair_in, rx_squelch_ok;
    logic collision_in_pair, collision_squelch_ok, pair_drive_out_p, pair_drive_out_n;
    logic pair_drive_delayed_p, pair_drive_delayed_n, saw_full, saw_col;
    logic        got[$], pgot[$];
    logic [15:0] bits;
    int          n, eofs, cycles, mismatches, compares;

    mec_line_codec mec_line_codec_i (.*);
    mec_line_partner mec_line_partner_i (.*);

    always #2 core_clk = ~core_clk;
    always #25 crystal_in = ~crystal_in;

    always @(posedge core_clk) begin
        cycles++;
        if (mac_rx_valid === 1'b1) got.push_back(mac_rx_data);
        if (pin_rx_valid === 1'b1) pgot.push_back(pin_rx_data);
        if (mac_rx_eof === 1'b1) eofs++;
        if (mac_collision === 1'b1 && pin_collision === 1'b1) saw_col = 1'b1;
        if (cycles == 40000) begin
            mismatches++;
            test_done();
        end
    end

    // ----
    // helpers
    // ----
    function automatic logic [31:0] pack(input logic q[$]);
        pack = 32'h0;
        foreach (q[i]) pack[i] = q[i];
    endfunction

    // expected half cells, tail high
    function automatic logic [31:0] halves_of(input logic [15:0] b, input int w);
        halves_of = 32'h0;
        for (int i = 0; i < w; i++) begin
            halves_of[2*i]   = ~b[i];
            halves_of[2*i+1] = b[i];
        end
        halves_of[2*w] = 1'b1;
    endfunction

    task automatic tick(input int c);
        repeat (c) @(posedge core_clk);
        #1;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic quiet();
        int q = 0, k = 0;
        while (q < 40 && k < 3000) begin
            @(posedge core_clk);
            k++;
            q = (pair_drive_out_p | pair_drive_out_n | pin_tx_en | mac_carrier_sense
                 | mac_collision) ? 0 : q + 1;
        end
        #1;
    endtask

    task automatic clear();
        got.delete();
        pgot.delete();
        mec_line_partner_i.halves.delete();
        eofs     = 0;
        saw_full = 1'b0;
        saw_col  = 1'b0;
        bits     = 16'($urandom);
    endtask

    // a mac stops offering bits once collision is raised
    task automatic send_tx(input logic [15:0] b, input int w);
        for (int i = 0; i < w; i++) begin
            mac_tx_valid = 1'b1;
            mac_tx_data  = b[i];
            mac_tx_last  = (i == w - 1);
            @(negedge core_clk);
            while (mac_tx_ready !== 1'b1 && mac_collision !== 1'b1) begin
                saw_full = 1'b1;
                @(negedge core_clk);
            end
            if (mac_collision === 1'b1) break;
            tick(1);
        end
        mac_tx_valid = 1'b0;
    endtask

    task automatic test_done();
        $display("TB: compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ----
    // tests
    // ----
    initial begin
        void'($urandom(63));
        tick(5);
        reset = 1'b0;
        tick(10);
        // frames 0 and 1 end on a zero and a one
        for (int t = 0; t < 4; t++) begin
            clear();
            n = 3 + $urandom_range(9);
            if (t < 2) bits[n-1] = t[0];
            send_tx(bits, n);
            quiet();
            chk("tx halves", halves_of(bits, n), pack(mec_line_partner_i.halves));
            chk("tx length", 2*n+1, mec_line_partner_i.halves.size());
            chk("tx stall", 1, saw_full);
            $display("TB: tx frame %0d done", t);
        end
        // frame 3 has squelch shut
        for (int t = 0; t < 4; t++) begin
            clear();
            n = 4 + $urandom_range(8);
            mec_line_partner_i.send_frame(bits, n, t != 3);
            quiet();
            if (t == 3) n = 0;
            bits = bits & ~(16'hFFFF << n);
            chk("rx bits", bits, pack(got));
            chk("rx count", n, got.size());
            chk("rx pins", bits, pack(pgot));
            chk("rx eof", n != 0, eofs);
            $display("TB: rx frame %0d done", t);
        end
        clear();
        fork
            send_tx(bits, 14);
            begin
                tick(200);
                mec_line_partner_i.collide(6);
            end
        join
        quiet();
        chk("collision seen", 1, saw_col);
        chk("frame cut", 1, mec_line_partner_i.halves.size() < 29);
        chk("cut tail", 1, mec_line_partner_i.halves[$]);
        chk("collision off", 0, mac_collision);
        chk("ready back", 1, mac_tx_ready);
        $display("TB: collision done");
        clear();
        codec_bypass_select = 1'b1;
        tick(10);
        ext_crs = 1'b1;
        for (int i = 0; i < 8; i++) begin
            ext_rx_data = bits[i];
            tick(6);
            ext_rx_clk = 1'b1;
            tick(6);
            ext_rx_clk = 1'b0;
        end
        ext_crs = 1'b0;
        quiet();
        chk("bypass bits", bits[7:0], pack(got));
        chk("bypass eof", 1, eofs);
        codec_bypass_select = 1'b0;
        tick(10);
        $display("TB: bypass done");
        test_done();
    end
endmodule

//--- dv/mec_line_partner.sv
// far side of the pairs: logs transmit half cells, sends frames and bursts
// assumes crystal_in is the free 20 MHz oscillator
`timescale 1ns/1ps

module mec_line_partner (
    // oscillator and our transmit pair
    input  wire logic crystal_in,
    input  wire logic pair_drive_out_p,
    input  wire logic pair_drive_out_n,
    // receive and collision pairs towards the codec
    output logic      rx_pair_in,
    output logic      rx_squelch_ok,
    output logic      collision_in_pair,
    output logic      collision_squelch_ok
);
    logic halves[$];

    initial begin
        rx_pair_in           = 1'b0;
        rx_squelch_ok        = 1'b0;
        collision_in_pair    = 1'b0;
        collision_squelch_ok = 1'b0;
    end

    // mid-tick sampling stays clear of the codec's synchroniser lag
    always @(negedge crystal_in) begin
        if (pair_drive_out_p | pair_drive_out_n) halves.push_back(pair_drive_out_p);
    end

    // line holds its last level after a frame
    task automatic send_frame(input logic [15:0] b, input int n, input logic sq);
        int j;
        rx_pair_in = ~b[0];
        #40;
        rx_squelch_ok = sq;
        #100;
        for (int i = 0; i < n; i++) begin
            j = $urandom_range(18) - 9;
            rx_pair_in = ~b[i];
            #(50 + j);
            rx_pair_in = b[i];
            #(50 - j);
        end
        #300;
        rx_squelch_ok = 1'b0;
    endtask

    task automatic collide(input int n);
        collision_squelch_ok = 1'b1;
        #100;
        repeat (n) begin
            collision_in_pair = 1'b1;
            #50;
            collision_in_pair = 1'b0;
            #50;
        end
        collision_squelch_ok = 1'b0;
    endtask
endmodule

//--- logic/mec_defs.svh
// timing and sizing constants for the manchester line codec
// assumes inclusion by the codec top only, core clock at 250 MHz
`ifndef MEC_DEFS_SVH
`define MEC_DEFS_SVH

// ----------------------------------------------------------------------------
// clocking
// ----------------------------------------------------------------------------
`define MEC_CORE_CLK_MHZ    250
`define MEC_XTAL_MHZ        20
`define MEC_XTAL_DIV        2

// ----------------------------------------------------------------------------
// line timing in ns, and the derived core-clock counts
// ----------------------------------------------------------------------------
`define MEC_BIT_NS          100
`define MEC_PREEMPH_NS      50
`define MEC_JITTER_NS       18
`define MEC_DEC_BLANK_NS    75
`define MEC_DEC_EOF_NS      130
`define MEC_COL_HOLD_NS     100
// least time, rounded up
`define MEC_DEC_BLANK_CYC   ((`MEC_DEC_BLANK_NS * `MEC_CORE_CLK_MHZ + 999) / 1000)
// longest times, rounded down
`define MEC_DEC_EOF_CYC     ((`MEC_DEC_EOF_NS * `MEC_CORE_CLK_MHZ) / 1000)
`define MEC_COL_HOLD_CYC    ((`MEC_COL_HOLD_NS * `MEC_CORE_CLK_MHZ) / 1000)

// ----------------------------------------------------------------------------
// transmit buffer
// ----------------------------------------------------------------------------
`define MEC_TXBUF_DEPTH     2
`define MEC_TXBUF_PTR_W     1

`endif

//--- logic/mec_line_codec.sv
// manchester line codec: encoder, twisted-pair drive with pre-emphasis copy,
// squelch-gated decoder, collision translator and crystal divider.
// assumes the mac runs on core_clk; crystal, line and external codec pins are
// asynchronous and are synchronised here.
`timescale 1ns/1ps
`include "mec_defs.svh"

module mec_line_codec
    import mec_pkg::*;
(
    // clock and reset
    input  wire logic core_clk,
    input  wire logic reset,
    // pins: crystal, bypass strap
    input  wire logic crystal_in,
    input  wire logic codec_bypass_select,
    // mac transmit stream
    input  wire logic mac_tx_valid,
    input  wire logic mac_tx_data,
    input  wire logic mac_tx_last,
    output logic      mac_tx_ready,
    // mac receive side
    output logic      mac_bit_clock,
    output logic      mac_rx_valid,
    output logic      mac_rx_data,
    output logic      mac_rx_eof,
    output logic      mac_carrier_sense,
    output logic      mac_collision,
    // line pins
    input  wire logic rx_pair_in,
    input  wire logic rx_squelch_ok,
    input  wire logic collision_in_pair,
    input  wire logic collision_squelch_ok,
    output logic      pair_drive_out_p,
    output logic      pair_drive_out_n,
    output logic      pair_drive_delayed_p,
    output logic      pair_drive_delayed_n,
    // external codec pins
    output logic      pin_tx_en,
    output logic      pin_tx_data,
    output logic      pin_rx_valid,
    output logic      pin_rx_data,
    output logic      pin_carrier_sense,
    output logic      pin_collision,
    input  wire logic ext_rx_clk,
    input  wire logic ext_rx_data,
    input  wire logic ext_crs,
    input  wire logic ext_col
);

    localparam logic [7:0] BLANK_CYC = 8'(`MEC_DEC_BLANK_CYC);
    localparam logic [7:0] EOF_CYC   = 8'(`MEC_DEC_EOF_CYC);
    localparam logic [7:0] COL_CYC   = 8'(`MEC_COL_HOLD_CYC);
    localparam int         NSYNC     = 10;

    // ------------------------------------------------------------------------
    // pin synchronisers: stage one feeds stage two only, stage three is edge history
    // ------------------------------------------------------------------------
    logic [NSYNC-1:0] sync1;
    logic [NSYNC-1:0] sync2;
    logic [NSYNC-1:0] sync3;
    logic [NSYNC-1:0] pins_in;

    assign pins_in = {ext_col, ext_crs, ext_rx_data, ext_rx_clk, collision_squelch_ok,
                      collision_in_pair, rx_squelch_ok, rx_pair_in, codec_bypass_select,
                      crystal_in};

    always_ff @(posedge core_clk) begin
        if (reset) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
        end else begin
            sync1 <= pins_in;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    logic xtal_tick;
    logic bypass;
    logic rx_level;
    logic rx_edge;
    logic rx_sq;
    logic col_edge;
    logic col_sq;
    logic ext_clk_rise;

    function automatic logic edge_of(input int idx, input logic [NSYNC-1:0] a,
                                     input logic [NSYNC-1:0] b);
        edge_of = a[idx] ^ b[idx];
    endfunction

    assign xtal_tick    = sync2[0] & ~sync3[0];
    assign bypass       = sync2[1];
    assign rx_level     = sync2[2];
    assign rx_edge      = edge_of(2, sync2, sync3);
    assign rx_sq        = sync2[3];
    assign col_edge     = edge_of(4, sync2, sync3);
    assign col_sq       = sync2[5];
    assign ext_clk_rise = sync2[6] & ~sync3[6];

    // ------------------------------------------------------------------------
    // crystal divider: every crystal rise is one half cell (50 ns)
    // ------------------------------------------------------------------------
    logic next_bit_clock;

    always_comb begin
        next_bit_clock = mac_bit_clock ^ xtal_tick;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            mac_bit_clock <= 1'b0;
        end else begin
            mac_bit_clock <= next_bit_clock;
        end
    end

    // ------------------------------------------------------------------------
    // two-entry transmit buffer; ready drops when full so the mac stalls
    // ------------------------------------------------------------------------
    mec_tx_bit_t              buf_mem [`MEC_TXBUF_DEPTH];
    mec_tx_bit_t              next_buf_mem [`MEC_TXBUF_DEPTH];
    logic [`MEC_TXBUF_PTR_W-1:0] wr_ptr;
    logic [`MEC_TXBUF_PTR_W-1:0] rd_ptr;
    logic [`MEC_TXBUF_PTR_W:0]   buf_count;
    logic [`MEC_TXBUF_PTR_W-1:0] next_wr_ptr;
    logic [`MEC_TXBUF_PTR_W-1:0] next_rd_ptr;
    logic [`MEC_TXBUF_PTR_W:0]   next_buf_count;
    logic                      buf_valid;
    logic                      buf_pop;
    logic                      buf_push;
    logic                      buf_flush;
    mec_tx_bit_t               buf_head;

    assign mac_tx_ready = (buf_count != 2'(`MEC_TXBUF_DEPTH)) & ~buf_flush;
    assign buf_valid    = (buf_count != '0);
    assign buf_head     = buf_mem[rd_ptr];
    assign buf_push     = mac_tx_valid & mac_tx_ready;

    always_comb begin
        next_buf_mem   = buf_mem;
        next_wr_ptr    = wr_ptr;
        next_rd_ptr    = rd_ptr;
        next_buf_count = buf_count;
        if (buf_flush) begin
            next_rd_ptr    = '0;
            next_wr_ptr    = '0;
            next_buf_count = '0;
        end else begin
            if (buf_push) begin
                next_buf_mem[wr_ptr] = '{data: mac_tx_data, last: mac_tx_last};
                next_wr_ptr          = wr_ptr + 1'b1;
            end
            if (buf_pop) begin
                next_rd_ptr = rd_ptr + 1'b1;
            end
            next_buf_count = buf_count + {1'b0, buf_push} - {1'b0, buf_pop};
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            buf_mem   <= '{default: '0};
            wr_ptr    <= '0;
            rd_ptr    <= '0;
            buf_count <= '0;
        end else begin
            buf_mem   <= next_buf_mem;
            wr_ptr    <= next_wr_ptr;
            rd_ptr    <= next_rd_ptr;
            buf_count <= next_buf_count;
        end
    end

    // ------------------------------------------------------------------------
    // encoder: one state step per half cell
    // ------------------------------------------------------------------------
    mec_enc_state_t enc_state;
    mec_enc_state_t next_enc_state;
    mec_tx_bit_t    cur_bit;
    mec_tx_bit_t    next_cur_bit;
    logic           line;
    logic           next_line;
    logic           drive_on;
    logic           next_drive_on;
    logic           dly_p;
    logic           dly_n;
    logic           next_dly_p;
    logic           next_dly_n;
    logic           next_pin_tx_en;
    logic           next_pin_tx_data;

    always_comb begin
        next_enc_state   = enc_state;
        next_cur_bit     = cur_bit;
        next_line        = line;
        next_drive_on    = drive_on;
        next_pin_tx_en   = pin_tx_en;
        next_pin_tx_data = pin_tx_data;
        buf_pop          = 1'b0;
        // a collision while the encoder is not idle empties the buffer so the mac can restart the frame later
        buf_flush        = mac_collision & (enc_state != ENC_IDLE);
        next_dly_p       = dly_p;
        next_dly_n       = dly_n;
        if (xtal_tick) begin
            next_dly_p = pair_drive_out_p;
            next_dly_n = pair_drive_out_n;
            case (enc_state)
                ENC_IDLE: begin
                    // in bypass the stream still drains, shown on pins only
                    if (buf_valid) begin
                        buf_pop        = 1'b1;
                        next_cur_bit   = buf_head;
                        next_line      = ~buf_head.data;
                        next_drive_on  = ~bypass;
                        next_pin_tx_en = 1'b1;
                        next_pin_tx_data = buf_head.data;
                        next_enc_state = ENC_FIRST;
                    end
                end
                ENC_FIRST: begin
                    next_line      = cur_bit.data;
                    next_enc_state = ENC_SECOND;
                end
                ENC_SECOND: begin
                    if (buf_valid & ~cur_bit.last & ~mac_collision) begin
                        buf_pop          = 1'b1;
                        next_cur_bit     = buf_head;
                        next_line        = ~buf_head.data;
                        next_pin_tx_data = buf_head.data;
                        next_enc_state   = ENC_FIRST;
                    end else begin
                        // high half cell: rising at cell end after a zero,
                        // held high after the mid-cell rise of a one
                        next_line      = 1'b1;
                        next_pin_tx_en = 1'b0;
                        next_enc_state = ENC_TAIL;
                    end
                end
                ENC_TAIL: begin
                    next_line      = 1'b0;
                    next_drive_on  = 1'b0;
                    next_enc_state = ENC_IDLE;
                end
                default: begin
                    next_enc_state = ENC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            enc_state   <= ENC_IDLE;
            cur_bit     <= '0;
            line        <= 1'b0;
            drive_on    <= 1'b0;
            dly_p       <= 1'b0;
            dly_n       <= 1'b0;
            pin_tx_en   <= 1'b0;
            pin_tx_data <= 1'b0;
        end else begin
            enc_state   <= next_enc_state;
            cur_bit     <= next_cur_bit;
            line        <= next_line;
            drive_on    <= next_drive_on;
            dly_p       <= next_dly_p;
            dly_n       <= next_dly_n;
            pin_tx_en   <= next_pin_tx_en;
            pin_tx_data <= next_pin_tx_data;
        end
    end

    // both outputs low when idle; delayed pair trails by one half cell
    assign pair_drive_out_p     = drive_on & line;
    assign pair_drive_out_n     = drive_on & ~line;
    assign pair_drive_delayed_p = dly_p;
    assign pair_drive_delayed_n = dly_n;

    // ------------------------------------------------------------------------
    // decoder: blanking past boundary edges, data is the level after mid-cell
    // ------------------------------------------------------------------------
    mec_dec_state_t dec_state;
    mec_dec_state_t next_dec_state;
    logic [7:0]     dec_cnt;
    logic [7:0]     next_dec_cnt;
    mec_rx_side_t   int_rx;
    mec_rx_side_t   next_int_rx;
    logic           int_eof;
    logic           next_int_eof;

    always_comb begin
        next_dec_state    = dec_state;
        next_dec_cnt      = dec_cnt;
        next_int_rx       = int_rx;
        next_int_rx.valid = 1'b0;
        next_int_eof      = 1'b0;
        case (dec_state)
            DEC_IDLE: begin
                // preamble carries only mid-cell edges, so the first edge locks
                if (rx_sq & rx_edge) begin
                    next_dec_state    = DEC_LOCK;
                    next_dec_cnt      = '0;
                    next_int_rx.valid = 1'b1;
                    next_int_rx.data  = rx_level;
                    next_int_rx.crs   = 1'b1;
                end
            end
            DEC_LOCK: begin
                next_dec_cnt = dec_cnt + 8'h01;
                // 75 ns blanking sits between 50+18 and 100-18 ns
                if (rx_edge & (dec_cnt >= BLANK_CYC)) begin
                    next_dec_cnt      = '0;
                    next_int_rx.valid = 1'b1;
                    next_int_rx.data  = rx_level;
                end else if (dec_cnt >= EOF_CYC) begin
                    next_dec_state  = DEC_IDLE;
                    next_int_eof    = 1'b1;
                    next_int_rx.crs = 1'b0;
                end
            end
            default: begin
                next_dec_state = DEC_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // collision translator: each qualified edge re-arms a one-bit hold
    // ------------------------------------------------------------------------
    logic [7:0] col_cnt;
    logic [7:0] next_col_cnt;

    always_comb begin
        next_col_cnt    = col_cnt;
        if (col_sq & col_edge) begin
            next_col_cnt = COL_CYC;
        end else if (col_cnt != '0) begin
            next_col_cnt = col_cnt - 8'h01;
        end
        next_int_rx.col = (next_col_cnt != '0);
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            dec_state <= DEC_IDLE;
            dec_cnt   <= '0;
            int_rx    <= '0;
            int_eof   <= 1'b0;
            col_cnt   <= '0;
        end else begin
            dec_state <= next_dec_state;
            dec_cnt   <= next_dec_cnt;
            int_rx    <= next_int_rx;
            int_eof   <= next_int_eof;
            col_cnt   <= next_col_cnt;
        end
    end

    // ------------------------------------------------------------------------
    // mac side selection and observation pins
    // ------------------------------------------------------------------------
    mec_rx_side_t ext_rx;
    mec_rx_side_t mac_rx;
    mec_rx_side_t next_mac_rx;
    logic         next_mac_eof;
    logic         ext_crs_d;

    assign ext_rx = '{valid: ext_clk_rise, data: sync2[7], crs: sync2[8], col: sync2[9]};

    always_comb begin
        if (bypass) begin
            next_mac_rx  = ext_rx;
            next_mac_eof = ext_crs_d & ~ext_rx.crs;
        end else begin
            next_mac_rx  = int_rx;
            next_mac_eof = int_eof;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            mac_rx     <= '0;
            mac_rx_eof <= 1'b0;
            ext_crs_d  <= 1'b0;
        end else begin
            mac_rx     <= next_mac_rx;
            mac_rx_eof <= next_mac_eof;
            ext_crs_d  <= ext_rx.crs;
        end
    end

    assign mac_rx_valid      = mac_rx.valid;
    assign mac_rx_data       = mac_rx.data;
    assign mac_carrier_sense = mac_rx.crs;
    assign mac_collision     = mac_rx.col;
    // internal codec's signals stay visible on pins in either mode
    assign pin_rx_valid      = int_rx.valid;
    assign pin_rx_data       = int_rx.data;
    assign pin_carrier_sense = int_rx.crs;
    assign pin_collision     = int_rx.col;

endmodule

//--- logic/mec_pkg.sv
// types shared by the manchester line codec
// assumes mec_defs.svh supplies all numeric constants
package mec_pkg;

    // ------------------------------------------------------------------------
    // state machines
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        ENC_IDLE   = 2'b00,
        ENC_FIRST  = 2'b01,
        ENC_SECOND = 2'b10,
        ENC_TAIL   = 2'b11
    } mec_enc_state_t;

    typedef enum logic [1:0] {
        DEC_IDLE = 2'b00,
        DEC_LOCK = 2'b01
    } mec_dec_state_t;

    // ------------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic data;
        logic last;
    } mec_tx_bit_t;

    typedef struct packed {
        logic valid;
        logic data;
        logic crs;
        logic col;
    } mec_rx_side_t;

endpackage
